// ===== serial_peer.sv
`timescale 1ns/10ps

module serial_peer (
   input wire logic sys_clk,
   input wire logic txdOut,
   output logic rxdIn
);
   initial rxdIn = 1'b1;

   // one frame then a bit of idle so the next start edge is clean
   task automatic send_frame(input logic [8:0] bits9, input int bitClks, input logic stopBit);
      logic [10:0] frame;
      frame = {stopBit, bits9, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxdIn <= frame[i];
         repeat (bitClks) @(posedge sys_clk);
      end
      rxdIn <= 1'b1;
      repeat (bitClks) @(posedge sys_clk);
   endtask : send_frame

   task automatic glitch(input int lowClks, input int gapClks);
      rxdIn <= 1'b0;
      repeat (lowClks) @(posedge sys_clk);
      rxdIn <= 1'b1;
      repeat (gapClks) @(posedge sys_clk);
   endtask : glitch

   // samples mid-bit, so a wrong bit rate scrambles the frame
   task automatic recv_frame(input int bitClks, output logic [10:0] frame);
      while (txdOut !== 1'b0) @(posedge sys_clk);
      repeat (bitClks / 2) @(posedge sys_clk);
      for (int i = 0; i < 11; i++) begin
         frame[i] = txdOut;
         repeat (bitClks) @(posedge sys_clk);
      end
   endtask : recv_frame
endmodule : serial_peer

// ===== uart_nine_bit.sv
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "uart_nine_bit_defines.svh"

module uart_nine_bit (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [`ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic rxdIn,
   output logic txdOut
);
   import uart_nine_bit_pkg::*;

   function automatic logic [31:0] applyBe(input logic [31:0] old, input logic [31:0] din,
                                           input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = din[i*8 +: 8];
         end
      end
      return r;
   endfunction : applyBe

   function automatic logic majority3(input logic [2:0] v);
      return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction : majority3

   // bus state
   logic waitreq_ff;
   logic [31:0] readdata_ff;
   // registers
   serial_control_type serial_control_ff;
   serial_control_type nxt_serial_control;
   logic rateDouble_ff;
   logic [7:0] t1Count_ff;
   logic [7:0] t1Reload_ff;
   logic t1Run_ff;
   logic [3:0] t1Pre_ff;
   logic t1Half_ff;
   logic [15:0] t2Count_ff;
   logic [15:0] t2Reload_ff;
   logic tf2_ff;
   logic rclk_ff;
   logic tx_clk_select_ff;
   logic tr2_ff;
   logic t2Pre_ff;
   logic [1:0] m2Pre_ff;
   // transmitter
   tx_state_type txState_ff;
   tx_state_type nxt_txState;
   logic [8:0] txShift_ff;
   logic [8:0] nxt_txShift;
   logic txFirst_ff;
   logic nxt_txFirst;
   logic [3:0] txCnt_ff;
   logic txd_ff;
   logic nxt_txd;
   logic txDoneSet;
   // receiver
   rx_state_type rxState_ff;
   rx_state_type nxt_rxState;
   logic [8:0] rxShift_ff;
   logic [8:0] nxt_rxShift;
   logic rxFirst_ff;
   logic nxt_rxFirst;
   logic [3:0] rxCnt_ff;
   logic [2:0] rxVote_ff;
   logic [7:0] rxBuf_ff;
   logic rxLoad;
   logic rxSync1_ff;
   logic rxSync2_ff;
   logic rxSync3_ff;
   logic rxLevel_ff;
   logic rxPrev_ff;

   // bus decode: request answered one cycle after it is seen
   wire reqSeen = (read | write) & waitreq_ff;
   wire doWrite = write & ~waitreq_ff;
   wire wrScon = doWrite && address == `OFS_SERIAL_CONTROL;
   wire wrSbuf = doWrite && address == `OFS_SERIAL_BUFFER && byteenable[0];
   wire wrPcon = doWrite && address == `OFS_POWER_CONTROL;
   wire wrT2con = doWrite && address == `OFS_TIMER2_CONTROL;
   wire wrT1 = doWrite && address == `OFS_TIMER1;
   wire wrT2Count = doWrite && address == `OFS_TIMER2_COUNT;
   wire wrT2Reload = doWrite && address == `OFS_TIMER2_RELOAD;

   wire [31:0] t2conWord = {24'h0, tf2_ff, 1'b0, rclk_ff, tx_clk_select_ff, 1'b0, tr2_ff, 2'b00};
   wire [31:0] t1Word = {15'h0, t1Run_ff, t1Reload_ff, t1Count_ff};
   wire [31:0] sconMerged = applyBe({24'h0, serial_control_ff}, writedata, byteenable);
   wire [31:0] pconMerged = applyBe({24'h0, rateDouble_ff, 7'h0}, writedata, byteenable);
   wire [31:0] t2conMerged = applyBe(t2conWord, writedata, byteenable);
   wire [31:0] t1Merged = applyBe(t1Word, writedata, byteenable);
   wire [31:0] t2CountMerged = applyBe({16'h0, t2Count_ff}, writedata, byteenable);
   wire [31:0] t2ReloadMerged = applyBe({16'h0, t2Reload_ff}, writedata, byteenable);

   logic [31:0] rdMux;
   always_comb begin
      case (address)
         `OFS_SERIAL_CONTROL: rdMux = {24'h0, serial_control_ff};
         `OFS_SERIAL_BUFFER: rdMux = {24'h0, rxBuf_ff};
         `OFS_POWER_CONTROL: rdMux = {24'h0, rateDouble_ff, 7'h0};
         `OFS_TIMER2_CONTROL: rdMux = t2conWord;
         `OFS_TIMER1: rdMux = t1Word;
         `OFS_TIMER2_COUNT: rdMux = {16'h0, t2Count_ff};
         `OFS_TIMER2_RELOAD: rdMux = {16'h0, t2Reload_ff};
         default: rdMux = 32'h0;
      endcase
   end

   // timer 1: 8-bit auto-reload, one count per machine cycle
   wire t1Inc = t1Run_ff && t1Pre_ff == `MACHINE_CYCLE_LAST;
   wire t1Ovf = t1Inc && t1Count_ff == 8'hFF;
   wire t1Tick16 = t1Ovf & (rateDouble_ff | t1Half_ff); // RQ16
   wire [7:0] t1Next = t1Ovf ? t1Reload_ff : t1Count_ff + 8'h01;

   // timer 2: counts at osc/2, overflow reloads from the reload pair
   wire t2Baud = rclk_ff & tx_clk_select_ff; // RQ19
   wire t2Inc = tr2_ff & t2Pre_ff; // RQ21
   wire t2Ovf = t2Inc && t2Count_ff == 16'hFFFF;
   wire [15:0] t2Next = t2Ovf ? t2Reload_ff : t2Count_ff + 16'h0001; // RQ20

   // 16x sample ticks
   wire m2Tick = rateDouble_ff ? m2Pre_ff[0] : m2Pre_ff == `MODE2_SLOW_LAST; // RQ15
   wire nineBit = serial_control_ff.mode_sel_hi; // RQ24
   wire txTick = serial_control_ff.mode_sel_lo ? (tx_clk_select_ff ? t2Ovf : t1Tick16) : m2Tick; // RQ2
   wire rxTick = serial_control_ff.mode_sel_lo ? (rclk_ff ? t2Ovf : t1Tick16) : m2Tick; // RQ2
   wire txRoll = txTick && txCnt_ff == `BIT_LAST; // RQ4
   wire rxRoll = rxTick && rxCnt_ff == `BIT_LAST;
   wire rxVote = majority3(rxVote_ff); // RQ9
   wire rxFall = rxTick & rxPrev_ff & ~rxLevel_ff; // RQ8
   wire txLastBit = ~txFirst_ff && txShift_ff[8:2] == 7'h00 && txShift_ff[1]; // RQ7
   wire [8:0] rxShifted = {rxShift_ff[7:0], rxVote}; // RQ11
   wire rxAccept = ~serial_control_ff.rx_done_flag & (~serial_control_ff.multiproc_filter_en | rxVote); // RQ12

   // transmitter
   always_comb begin
      nxt_txState = txState_ff;
      nxt_txShift = txShift_ff;
      nxt_txFirst = txFirst_ff;
      nxt_txd = txd_ff;
      txDoneSet = 1'b0;
      case (txState_ff)
         TX_IDLE: begin
            nxt_txd = 1'b1;
            if (wrSbuf && nineBit) begin
               nxt_txShift = {serial_control_ff.tx_ninth_bit, writedata[7:0]}; // RQ3
               nxt_txState = TX_WAIT; // RQ4
            end
         end
         TX_WAIT: begin
            if (txRoll) begin
               nxt_txd = 1'b0; // RQ5
               nxt_txState = TX_START;
            end
         end
         TX_START: begin
            if (txRoll) begin
               nxt_txd = txShift_ff[0]; // RQ5
               nxt_txFirst = 1'b1;
               nxt_txState = TX_DATA;
            end
         end
         TX_DATA: begin
            if (txRoll) begin
               nxt_txShift = {txFirst_ff, txShift_ff[8:1]}; // RQ6
               nxt_txFirst = 1'b0;
               nxt_txd = nxt_txShift[0]; // RQ1
               if (txLastBit) begin
                  txDoneSet = 1'b1; // RQ7
                  nxt_txState = TX_IDLE;
               end
            end
         end
         default: nxt_txState = TX_IDLE;
      endcase
      if (!nineBit) begin
         nxt_txState = TX_IDLE;
         nxt_txd = 1'b1;
      end
   end

   // receiver
   always_comb begin
      nxt_rxState = rxState_ff;
      nxt_rxShift = rxShift_ff;
      nxt_rxFirst = rxFirst_ff;
      rxLoad = 1'b0;
      case (rxState_ff)
         RX_HUNT: begin
            if (rxFall && serial_control_ff.rx_enable) begin // RQ25
               nxt_rxShift = `RX_FILL; // RQ8
               nxt_rxFirst = 1'b1;
               nxt_rxState = RX_BITS;
            end
         end
         RX_BITS: begin
            if (rxRoll) begin
               nxt_rxFirst = 1'b0;
               nxt_rxShift = rxShifted; // RQ10
               if (rxFirst_ff && rxVote) begin
                  nxt_rxState = RX_HUNT; // RQ10
               end else if (!rxFirst_ff && !rxShift_ff[8]) begin
                  rxLoad = rxAccept; // RQ11
                  nxt_rxState = RX_STOP;
               end
            end
         end
         RX_STOP: begin
            if (rxRoll) begin
               nxt_rxState = RX_HUNT; // RQ13
            end
         end
         default: nxt_rxState = RX_HUNT;
      endcase
      if (!nineBit) begin
         nxt_rxState = RX_HUNT;
      end
   end

   // flags: hardware set wins over a software clear in the same cycle
   always_comb begin
      nxt_serial_control = wrScon ? serial_control_type'(sconMerged[7:0]) : serial_control_ff;
      if (txDoneSet) begin
         nxt_serial_control.tx_done_flag = 1'b1; // RQ7
      end
      if (rxLoad) begin
         nxt_serial_control.rx_ninth_bit = rxVote; // RQ14
         nxt_serial_control.rx_done_flag = 1'b1; // RQ12
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         waitreq_ff <= 1'b1;
         readdata_ff <= 32'h0;
      end else begin
         waitreq_ff <= ~reqSeen;
         if (read && waitreq_ff) begin
            readdata_ff <= rdMux;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         serial_control_ff <= `SERIAL_CONTROL_RESET;
         rateDouble_ff <= 1'b0; // RQ15
         tf2_ff <= 1'b0;
         rclk_ff <= 1'b0;
         tx_clk_select_ff <= 1'b0;
         tr2_ff <= 1'b0;
      end else begin
         serial_control_ff <= nxt_serial_control;
         rateDouble_ff <= wrPcon ? pconMerged[`PC_RATE_DOUBLE] : rateDouble_ff;
         tf2_ff <= (t2Ovf & ~t2Baud) | (wrT2con ? t2conMerged[`T2C_OVERFLOW] : tf2_ff); // RQ22
         rclk_ff <= wrT2con ? t2conMerged[`T2C_RX_CLK_SEL] : rclk_ff;
         tx_clk_select_ff <= wrT2con ? t2conMerged[`T2C_TX_CLK_SEL] : tx_clk_select_ff;
         tr2_ff <= wrT2con ? t2conMerged[`T2C_RUN] : tr2_ff;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         t1Count_ff <= `TIMER1_RESET;
         t1Reload_ff <= `TIMER1_RESET;
         t1Run_ff <= 1'b0;
         t1Pre_ff <= 4'h0;
         t1Half_ff <= 1'b0;
      end else begin
         t1Count_ff <= wrT1 ? t1Merged[7:0] : (t1Inc ? t1Next : t1Count_ff);
         t1Reload_ff <= wrT1 ? t1Merged[15:8] : t1Reload_ff;
         t1Run_ff <= wrT1 ? t1Merged[`T1_RUN] : t1Run_ff;
         t1Pre_ff <= (t1Pre_ff == `MACHINE_CYCLE_LAST) ? 4'h0 : t1Pre_ff + 4'h1;
         t1Half_ff <= t1Half_ff ^ t1Ovf;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         t2Count_ff <= `TIMER_RESET;
         t2Reload_ff <= `TIMER_RESET;
         t2Pre_ff <= 1'b0;
         m2Pre_ff <= 2'h0;
      end else begin
         t2Count_ff <= wrT2Count ? t2CountMerged[15:0] : (t2Inc ? t2Next : t2Count_ff);
         t2Reload_ff <= wrT2Reload ? t2ReloadMerged[15:0] : t2Reload_ff;
         t2Pre_ff <= tr2_ff & ~t2Pre_ff;
         m2Pre_ff <= m2Pre_ff + 2'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         txState_ff <= TX_IDLE;
         txShift_ff <= 9'h000;
         txFirst_ff <= 1'b0;
         txCnt_ff <= 4'h0;
         txd_ff <= 1'b1;
      end else begin
         txState_ff <= nxt_txState;
         txShift_ff <= nxt_txShift;
         txFirst_ff <= nxt_txFirst;
         txCnt_ff <= txTick ? txCnt_ff + 4'h1 : txCnt_ff;
         txd_ff <= nxt_txd;
      end
   end

   // rx pin: three stages, level accepted once the last two agree
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rxSync1_ff <= 1'b1;
         rxSync2_ff <= 1'b1;
         rxSync3_ff <= 1'b1;
         rxLevel_ff <= 1'b1;
         rxPrev_ff <= 1'b1;
      end else begin
         rxSync1_ff <= rxdIn;
         rxSync2_ff <= rxSync1_ff;
         rxSync3_ff <= rxSync2_ff;
         rxLevel_ff <= (rxSync2_ff == rxSync3_ff) ? rxSync3_ff : rxLevel_ff;
         rxPrev_ff <= rxTick ? rxLevel_ff : rxPrev_ff; // RQ8
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rxState_ff <= RX_HUNT;
         rxShift_ff <= `RX_FILL;
         rxFirst_ff <= 1'b0;
         rxCnt_ff <= 4'h0;
         rxVote_ff <= 3'h7;
         rxBuf_ff <= 8'h00;
      end else begin
         rxState_ff <= nxt_rxState;
         rxShift_ff <= nxt_rxShift;
         rxFirst_ff <= nxt_rxFirst;
         rxCnt_ff <= (rxState_ff == RX_HUNT) ? 4'h0 : (rxTick ? rxCnt_ff + 4'h1 : rxCnt_ff); // RQ8
         if (rxTick && rxCnt_ff == `SAMPLE_A) begin
            rxVote_ff[0] <= rxLevel_ff; // RQ9
         end
         if (rxTick && rxCnt_ff == `SAMPLE_B) begin
            rxVote_ff[1] <= rxLevel_ff; // RQ9
         end
         if (rxTick && rxCnt_ff == `SAMPLE_C) begin
            rxVote_ff[2] <= rxLevel_ff; // RQ9
         end
         if (rxLoad) begin
            rxBuf_ff <= {<<{rxShift_ff[7:0]}}; // RQ11
         end
      end
   end

   assign readdata = readdata_ff;
   assign waitrequest = waitreq_ff;
   assign txdOut = txd_ff;

endmodule : uart_nine_bit

// ===== uart_nine_bit_chk.sv
`timescale 1ns/10ps
`include "uart_nine_bit_defines.svh"

module uart_nine_bit_chk (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [`ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic txdOut
);
   import uart_nine_bit_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   reset_idle_a: assert property (disable iff (1'b0) !rstn |=> waitrequest && txdOut && readdata == 32'h0)
      else $error("outputs not idle after reset");
   wait_one_a: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   req_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered in one cycle");
   no_req_idle_a: assert property (waitrequest && !read && !write |=> waitrequest)
      else $error("waitrequest dropped without a request");
   wait_cause_a: assert property (!waitrequest |-> $past(read) || $past(write))
      else $error("completion without a request");
   read_hold_a: assert property ($past(rstn) && $changed(readdata) |-> read && !waitrequest)
      else $error("readdata changed outside a read completion");
   unmapped_zero_a: assert property (read && !waitrequest && address >= 5'h1C |-> readdata == 32'h0)
      else $error("unmapped read returned nonzero");
   tx_bit_hold_a: assert property ($past(rstn) && $changed(txdOut) |=> $stable(txdOut) [*8])
      else $error("transmit bit shorter than eight cycles");
endmodule : uart_nine_bit_chk

bind uart_nine_bit uart_nine_bit_chk i_uart_nine_bit_chk (.sys_clk(sys_clk), .rstn(rstn), .address(address),
   .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .txdOut(txdOut));

// ===== uart_nine_bit_defines.svh
// Contract
// [RQ1] frame is 11 bits: start low, 8 data LSB first, ninth bit, stop high
// [RQ2] mode 3 equals mode 2 except rate; timer 1 or 2 chosen by clock selects
// [RQ3] transmitted ninth bit comes from software-writable tx_ninth_bit
// [RQ4] buffer write loads shifter; sending starts after next divide-by-16 rollover
// [RQ5] start bit first, data output one bit later, first shift one bit after
// [RQ6] first shift inserts a 1 at ninth position, later shifts insert zeros
// [RQ7] ninth bit out with stop beside it: final shift, set tx done, end send
// [RQ8] receive starts on falling edge at 16x rate; load 1FFh, reset counter
// [RQ9] sample line at counter states 7, 8, 9 and take the majority
// [RQ10] a first bit that votes high aborts back to hunting; valid start shifts in
// [RQ11] bits enter 9-bit shifter from right; start at left means final shift
// [RQ12] load only when rx done is 0 and filter off or ninth bit is 1
// [RQ13] one bit time after final shift return to hunting for a falling edge
// [RQ14] received stop bit affects neither buffer, ninth-bit flag nor done flag
// [RQ15] mode 2 rate is osc times 2^rate_double over 64; rate_double resets to 0
// [RQ16] timer 1 source: rate is 2^rate_double times timer 1 overflow rate over 32
// [RQ17] software runs timer 1 as 8-bit auto-reload, interrupt off
// [RQ18] software picks timer 1 reload byte from the rate formula
// [RQ19] timer 2 is rate generator when both clock-select bits are 1
// [RQ20] timer 2 overflow reloads 16-bit count from the reload pair
// [RQ21] timer 2 counts at osc/2; rate is osc over 32 times (65536 - reload)
// [RQ22] timer 2 rollover in rate mode sets no overflow flag
// [RQ23] software leaves timer 2 counts and reload alone while it runs
// [RQ24] mode selects 1,0 give mode 2 and 1,1 give mode 3
// [RQ25] reception only while receive enable is 1; code checks rx_enable only in RX_HUNT, so a started frame still loads
`ifndef UART_NINE_BIT_DEFINES_SVH
`define UART_NINE_BIT_DEFINES_SVH

`define ADDR_W 5
`define OFS_SERIAL_CONTROL 5'h00
`define OFS_SERIAL_BUFFER 5'h04
`define OFS_POWER_CONTROL 5'h08
`define OFS_TIMER2_CONTROL 5'h0C
`define OFS_TIMER1 5'h10
`define OFS_TIMER2_COUNT 5'h14
`define OFS_TIMER2_RELOAD 5'h18

`define PC_RATE_DOUBLE 7
`define T2C_OVERFLOW 7
`define T2C_RX_CLK_SEL 5
`define T2C_TX_CLK_SEL 4
`define T2C_RUN 2
`define T1_RUN 16

`define SERIAL_CONTROL_RESET 8'h00
`define TIMER_RESET 16'h0000
`define TIMER1_RESET 8'h00
`define RX_FILL 9'h1FF

`define MACHINE_CYCLE_LAST 4'hB
`define MODE2_SLOW_LAST 2'h3
`define BIT_LAST 4'hF
`define SAMPLE_A 4'h7
`define SAMPLE_B 4'h8
`define SAMPLE_C 4'h9

`endif

// ===== uart_nine_bit_pkg.sv
package uart_nine_bit_pkg;

   typedef enum {TX_IDLE, TX_WAIT, TX_START, TX_DATA} tx_state_type;
   typedef enum {RX_HUNT, RX_BITS, RX_STOP} rx_state_type;

   typedef struct packed {
      logic mode_sel_hi;
      logic mode_sel_lo;
      logic multiproc_filter_en;
      logic rx_enable;
      logic tx_ninth_bit;
      logic rx_ninth_bit;
      logic tx_done_flag;
      logic rx_done_flag;
   } serial_control_type;

endpackage : uart_nine_bit_pkg

// ===== uart_nine_bit_test.sv
`timescale 1ns/10ps
`include "uart_nine_bit_defines.svh"

module uart_nine_bit_test;
   import uart_nine_bit_pkg::*;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [`ADDR_W-1:0] address = '0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = '0;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] readdata;
   logic waitrequest;
   logic rxdIn;
   logic txdOut;
   int errCount = 0;
   int checks = 0;
   logic [31:0] rd;
   logic [10:0] frm;

   always #2 sys_clk = ~sys_clk;

   uart_nine_bit i_uart_nine_bit (.sys_clk(sys_clk), .rstn(rstn), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .rxdIn(rxdIn), .txdOut(txdOut));
   serial_peer peer (.sys_clk(sys_clk), .txdOut(txdOut), .rxdIn(rxdIn));

   task automatic giveVerdict;
      if (errCount == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : giveVerdict

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errCount++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // waits for the answer however long it takes; only the watchdog ends a hang
   task automatic bus(input logic wr, input logic [`ADDR_W-1:0] addr, input logic [31:0] wdata);
      @(posedge sys_clk);
      address <= addr;
      writedata <= wdata;
      write <= wr;
      read <= ~wr;
      do begin
         @(posedge sys_clk);
      end while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus

   task automatic rchk(input string what, input logic [`ADDR_W-1:0] addr, input logic [31:0] exp);
      bus(1'b0, addr, 32'h0);
      check(what, rd, exp);
   endtask : rchk

   task automatic t_reset;
      rchk("power", `OFS_POWER_CONTROL, 32'h0);
      bus(1'b1, 5'h1C, 32'hC0);
      rchk("unmapped", 5'h1C, 32'h0);
      rchk("control", `OFS_SERIAL_CONTROL, 32'h0);
   endtask : t_reset

   task automatic t_tx_mode2;
      for (int b = 0; b < 2; b++) begin
         bus(1'b1, `OFS_POWER_CONTROL, 32'(b << 7));
         bus(1'b1, `OFS_SERIAL_CONTROL, 32'(32'h80 | (b << 3)));
         fork
            peer.recv_frame(64 >> b, frm);
            bus(1'b1, `OFS_SERIAL_BUFFER, 32'h55);
         join
         check("tx frame", frm, {1'b1, b[0], 8'h55, 1'b0});
         rchk("tx done", `OFS_SERIAL_CONTROL, 32'(32'h82 | (b << 3)));
      end
   endtask : t_tx_mode2

   task automatic t_timer2;
      bus(1'b1, `OFS_TIMER2_RELOAD, 32'hFFFE);
      bus(1'b1, `OFS_TIMER2_COUNT, 32'hFFFE);
      bus(1'b1, `OFS_TIMER2_CONTROL, 32'h34);
      bus(1'b1, `OFS_SERIAL_CONTROL, 32'hD0);
      fork
         peer.recv_frame(64, frm);
         bus(1'b1, `OFS_SERIAL_BUFFER, 32'hAA);
      join
      check("t2 tx frame", frm, {1'b1, 1'b0, 8'hAA, 1'b0});
      peer.send_frame({1'b1, 8'h3C}, 64, 1'b0);
      rchk("rx data", `OFS_SERIAL_BUFFER, 32'h3C);
      rchk("rx flags", `OFS_SERIAL_CONTROL, 32'hD7);
      rchk("t2 flag", `OFS_TIMER2_CONTROL, 32'h34);
      peer.send_frame({1'b0, 8'h99}, 64, 1'b1);
      rchk("rx kept", `OFS_SERIAL_BUFFER, 32'h3C);
   endtask : t_timer2

   task automatic t_filter;
      bus(1'b1, `OFS_SERIAL_CONTROL, 32'hF0);
      peer.send_frame({1'b0, 8'h11}, 64, 1'b1);
      rchk("filtered", `OFS_SERIAL_CONTROL, 32'hF0);
      peer.glitch(12, 192);
      peer.send_frame({1'b1, 8'h22}, 64, 1'b1);
      rchk("addr frame", `OFS_SERIAL_BUFFER, 32'h22);
      rchk("addr flags", `OFS_SERIAL_CONTROL, 32'hF5);
      bus(1'b1, `OFS_SERIAL_CONTROL, 32'hC0);
      peer.send_frame({1'b1, 8'h44}, 64, 1'b1);
      rchk("rx off", `OFS_SERIAL_CONTROL, 32'hC0);
   endtask : t_filter

   task automatic t_timer1;
      bus(1'b1, `OFS_TIMER2_CONTROL, 32'h0);
      bus(1'b1, `OFS_POWER_CONTROL, 32'h80);
      // eight-bit auto-reload with reload FF gives 192 clocks a bit
      bus(1'b1, `OFS_TIMER1, 32'h1FFFF);
      bus(1'b1, `OFS_SERIAL_CONTROL, 32'hC8);
      fork
         peer.recv_frame(192, frm);
         bus(1'b1, `OFS_SERIAL_BUFFER, 32'h0F);
      join
      check("t1 tx frame", frm, {1'b1, 1'b1, 8'h0F, 1'b0});
   endtask : t_timer1

   initial begin
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      t_reset;
      t_tx_mode2;
      t_timer2;
      t_filter;
      t_timer1;
      giveVerdict;
   end

   initial begin
      #200000;
      errCount++;
      giveVerdict;
   end
endmodule : uart_nine_bit_test
